// >>> rtl/mmac_access_control.sv
// Purpose: mode based address translation and access checking
// Assumes: cpu signals and table memory on mclk; apb master on mclk
// Notes: segment entries are fetched from memory into a local table
// How it works
// RL1: mode is derived from status word high bit and two mode bits
// RL2: each segment holds rights, first/last address and relocation offset
// RL3: each segment also grants hardware register read and write
// RL4: a segment with no right at all never matches
// RL5: zero to all entries may be defined; count is a register
// RL6: cpu gives virtual addresses; unit issues translated physical ones
// RL7: every access is checked before memory sees it
// RL8: memory read, write, execute and register read, write checked apart
// RL9: table pointer register tells where the table is fetched from
// RL10: firewall and exchange window steer contactless os rights
// RL11: rom, eeprom and ram split into test/os and application parts
// RL12: without contactless os, top 128 eeprom bytes reserved, ram whole
// RL13: refused register read gives zero, refused write is dropped
// RL14: user mode limited by segments, system mode sees application memory
// RL15: refused memory access is blocked and flagged to the cpu
`timescale 1ns/10ps
`default_nettype none

module mmac_access_control
  import mmac_pkg::*;
#(
  parameter int NSEG       = 64,
  parameter bit CL_PRESENT = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [7:0]  programStatusHigh,
  input  wire logic [1:0]  modeBits,
  input  wire logic        cpuReq,
  input  wire logic [15:0] cpuVaddr,
  input  wire logic [1:0]  cpuOp,
  output var  logic        cpuBusy,
  output var  logic        cpuFault,
  output var  logic        memReq,
  output var  logic [15:0] memPaddr,
  output var  logic [1:0]  memOp,
  output var  logic        tblReq,
  output var  logic [15:0] tblAddr,
  input  wire logic [31:0] tblRdata,
  input  wire logic        tblAck,
  input  wire logic        sfrReq,
  input  wire logic        sfrWrite,
  input  wire logic        sfrHw,
  input  wire logic [3:0]  sfrUnit,
  output var  logic        sfrGrant,
  output var  logic        sfrDeny
);

  localparam int IW = (NSEG > 1) ? $clog2(NSEG) : 1;
  localparam int CW = $clog2(NSEG + 1);

  generate
    if (NSEG < 1 || NSEG > SEG_MAX) begin : g_bad
      $error("NSEG must be 1 to 64");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SCAN, ST_CHECK} mmac_state_e;

  mmac_mode_e    curMode;
  mmac_mode_e    reqMode_reg;
  mmac_state_e   state_reg;
  mmac_state_e   state_next;
  logic          priv;
  logic [CW-1:0] nseg_reg;
  logic [CW-1:0] idx_reg;
  logic          half_reg;
  logic          loadPend_reg;
  logic [15:0]   tblPtr_reg;
  logic [7:0]    fwLo_reg;
  logic [7:0]    fwHi_reg;
  logic [7:0]    xbLo_reg;
  logic [7:0]    xbHi_reg;
  logic [7:0]    xsLo_reg;
  logic [7:0]    xsHi_reg;
  logic [31:0]   tblW0 [NSEG];
  logic [31:0]   tblW1 [NSEG];
  logic [15:0]   reqVa_reg;
  logic [15:0]   pa_reg;
  logic [1:0]    reqOp_reg;
  logic [1:0]    segSfr_reg;
  logic          fault_reg;
  logic          setup;
  logic          wrAcc;
  logic          loadCmd;
  logic          faultClr;
  logic          lastWord;
  logic          faultEv;
  logic          grantEv;
  logic          regionOk;
  logic          sfrOk;
  logic          mapped;
  logic [31:0]   rdMux;
  logic [15:0]   fwBits;
  logic [15:0]   xBase;
  logic [15:0]   xSize;
  logic [IW-1:0] ix;

  mmac_seg_if segIf ();

  ////////////////////////////////////////////////////////////////////////
  // mode and privilege
  always_comb begin : mode_decode
    case (modeBits)                                                // [RL1]
      MB_BOOT: curMode = MD_BOOT;
      MB_TEST: curMode = MD_TEST;
      MB_CLOS: curMode = CL_PRESENT ? MD_CLOS : MD_SYS;            // [RL12]
      default: curMode = programStatusHigh[PSW_SYS_BIT] ? MD_SYS : MD_USER;
    endcase
  end

  assign priv   = (curMode != MD_USER) && (curMode != MD_CLOS);
  assign fwBits = {fwHi_reg, fwLo_reg};
  assign xBase  = {xbHi_reg, xbLo_reg};
  assign xSize  = {xsHi_reg, xsLo_reg};

  ////////////////////////////////////////////////////////////////////////
  // apb slave: wait state free access, answer in access phase
  assign setup    = psel && !penable;
  assign wrAcc    = psel && penable && pwrite && pready && priv;   // [RL13]
  assign loadCmd  = wrAcc && (paddr == REG_CTRL) && pwdata[CTRL_LOAD_BIT];
  assign faultClr = wrAcc && (paddr == REG_STATUS) && pwdata[STAT_FAULT_BIT];

  // read mux, refused reads give zero
  always_comb begin : read_mux
    mapped = 1'b1;
    rdMux  = '0;
    case (paddr)
      REG_CTRL:     rdMux[CTRL_NSEG_LSB +: CW] = nseg_reg;
      REG_TBLPTR:   rdMux[15:0] = tblPtr_reg;
      REG_FWCTL_LO: rdMux[7:0] = fwLo_reg;
      REG_FWCTL_HI: rdMux[7:0] = fwHi_reg;
      REG_XBASE_LO: rdMux[7:0] = xbLo_reg;
      REG_XBASE_HI: rdMux[7:0] = xbHi_reg;
      REG_XSIZE_LO: rdMux[7:0] = xsLo_reg;
      REG_XSIZE_HI: rdMux[7:0] = xsHi_reg;
      REG_STATUS: begin
        rdMux[STAT_BUSY_BIT]       = (state_reg != ST_IDLE) || loadPend_reg;
        rdMux[STAT_FAULT_BIT]      = fault_reg;
        rdMux[STAT_MODE_LSB +: 3]  = curMode;
      end
      default:      mapped = 1'b0;
    endcase
    if (!priv && paddr != REG_STATUS) begin
      rdMux = '0;                                                  // [RL13]
    end
  end

  // bus answer flops
  always_ff @(posedge mclk or posedge rst) begin : apb_answer
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rdMux : '0;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or posedge rst) begin : cfg_regs
    if (rst) begin
      nseg_reg   <= '0;
      tblPtr_reg <= PTR_RST;
      fwLo_reg   <= FW_RST;
      fwHi_reg   <= FW_RST;
      xbLo_reg   <= XW_RST;
      xbHi_reg   <= XW_RST;
      xsLo_reg   <= XW_RST;
      xsHi_reg   <= XW_RST;
    end else if (wrAcc) begin
      case (paddr)
        REG_CTRL: begin                                            // [RL5]
          if (pwdata[CTRL_NSEG_LSB +: NSEG_FW] > NSEG_FW'(NSEG)) begin
            nseg_reg <= CW'(NSEG);
          end else begin
            nseg_reg <= pwdata[CTRL_NSEG_LSB +: CW];
          end
        end
        REG_TBLPTR:   tblPtr_reg <= pwdata[15:0];                  // [RL9]
        REG_FWCTL_LO: fwLo_reg <= pwdata[7:0];                     // [RL10]
        REG_FWCTL_HI: fwHi_reg <= pwdata[7:0];
        REG_XBASE_LO: xbLo_reg <= pwdata[7:0];
        REG_XBASE_HI: xbHi_reg <= pwdata[7:0];
        REG_XSIZE_LO: xsLo_reg <= pwdata[7:0];
        REG_XSIZE_HI: xsHi_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // pending table load and sticky fault, set wins over clear
  always_ff @(posedge mclk or posedge rst) begin : flags
    if (rst) begin
      loadPend_reg <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      loadPend_reg <= loadCmd || (loadPend_reg && !(state_reg == ST_IDLE && !cpuReq));
      fault_reg    <= faultEv || (fault_reg && !faultClr);        // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // segment lookup on the current scan index
  assign ix          = idx_reg[IW-1:0];
  assign segIf.vaddr = reqVa_reg;
  assign segIf.op    = reqOp_reg;
  assign segIf.w0    = tblW0[ix];
  assign segIf.w1    = tblW1[ix];

  mmac_seg_check u_seg (
    .sp (segIf.match)
  );

  // physical region check per request mode
  always_comb begin : region_check
    logic inTRom, inARom, inEe, inCEe, inAEe, inRam, inCRam, inARam, inX;
    logic romOp, ramOp, clArea, apArea;
    inTRom = pa_reg <= ROM_TEST_END;                               // [RL11]
    inARom = (pa_reg > ROM_TEST_END) && (pa_reg <= ROM_END);
    inEe   = (pa_reg >= EE_BASE) && (pa_reg <= EE_END);
    inCEe  = CL_PRESENT && inEe && (pa_reg <= EE_CL_END);
    inAEe  = inEe && !inCEe && (CL_PRESENT || pa_reg < EE_MFR_BASE); // [RL12]
    inRam  = pa_reg >= RAM_BASE;
    inCRam = CL_PRESENT && inRam && (pa_reg <= RAM_CL_END);
    inARam = inRam && !inCRam;
    inX    = (pa_reg >= xBase) && (16'(pa_reg - xBase) < xSize);   // [RL10]
    romOp  = reqOp_reg != OP_WRITE;                                // [RL8]
    ramOp  = reqOp_reg != OP_EXEC;
    clArea = (inTRom && romOp) || inCEe || (inCRam && ramOp);
    apArea = (inARom && romOp) || inAEe || (inARam && ramOp);
    case (reqMode_reg)
      MD_BOOT: regionOk = clArea;
      MD_TEST: regionOk = ((inTRom || inARom) && romOp) || inEe || (inRam && ramOp);
      MD_CLOS: regionOk = clArea || (inARam && ramOp && inX);
      default: regionOk = apArea;                                  // [RL14]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // control state machine
  assign lastWord = tblReq && tblAck && half_reg && (CW'(idx_reg + 1'b1) == nseg_reg);

  always_comb begin : fsm_next
    state_next = state_reg;
    faultEv    = 1'b0;
    grantEv    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cpuReq) begin
          state_next = (curMode == MD_USER) ? ST_SCAN : ST_CHECK; // [RL14]
        end else if (loadPend_reg && nseg_reg != '0) begin
          state_next = ST_FETCH;                                   // [RL9]
        end
      end
      ST_FETCH: begin
        if (lastWord) begin
          state_next = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (idx_reg == nseg_reg) begin
          faultEv    = 1'b1;                                       // [RL5]
          state_next = ST_IDLE;
        end else if (segIf.hit) begin
          faultEv    = !segIf.permit;                              // [RL7]
          state_next = segIf.permit ? ST_CHECK : ST_IDLE;
        end
      end
      ST_CHECK: begin
        grantEv    = regionOk;                                     // [RL7]
        faultEv    = !regionOk;                                    // [RL15]
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin : fsm_state
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request capture, scan and fetch indices
  always_ff @(posedge mclk or posedge rst) begin : datapath
    if (rst) begin
      idx_reg     <= '0;
      half_reg    <= 1'b0;
      reqVa_reg   <= '0;
      reqOp_reg   <= OP_READ;
      reqMode_reg <= MD_BOOT;
      pa_reg      <= '0;
      segSfr_reg  <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          idx_reg  <= '0;
          half_reg <= 1'b0;
          if (cpuReq) begin
            reqVa_reg   <= cpuVaddr;
            reqOp_reg   <= cpuOp;
            reqMode_reg <= curMode;
            pa_reg      <= cpuVaddr;                               // [RL6]
          end
        end
        ST_FETCH: begin
          if (tblReq && tblAck) begin
            half_reg <= !half_reg;
            if (half_reg) begin
              idx_reg <= CW'(idx_reg + 1'b1);
            end
          end
        end
        ST_SCAN: begin
          // an index past the defined entries may point at stale words
          if (idx_reg != nseg_reg && segIf.hit) begin
            pa_reg <= segIf.paddr;                                 // [RL6]
            if (segIf.permit && reqOp_reg == OP_EXEC) begin
              segSfr_reg <= {segIf.w1[E_SW], segIf.w1[E_SR]};      // [RL3]
            end
          end else if (idx_reg != nseg_reg) begin
            idx_reg <= CW'(idx_reg + 1'b1);
          end
        end
        default: ;
      endcase
    end
  end

  // local segment table, filled by the fetch walk
  always_ff @(posedge mclk) begin : table_store
    if (state_reg == ST_FETCH && tblReq && tblAck) begin
      if (half_reg) begin
        tblW1[ix] <= tblRdata;                                     // [RL2]
      end else begin
        tblW0[ix] <= tblRdata;
      end
    end
  end

  // table memory handshake, one idle cycle between words
  always_ff @(posedge mclk or posedge rst) begin : table_port
    if (rst) begin
      tblReq  <= 1'b0;
      tblAddr <= '0;
    end else if (state_reg == ST_IDLE) begin
      tblReq  <= state_next == ST_FETCH;
      tblAddr <= tblPtr_reg;                                       // [RL9]
    end else if (state_reg == ST_FETCH) begin
      if (tblReq && tblAck) begin
        tblReq  <= 1'b0;
        tblAddr <= 16'(tblAddr + TBL_STEP);
      end else begin
        tblReq  <= 1'b1;
      end
    end else begin
      tblReq <= 1'b0;
    end
  end

  // cpu and memory side outputs
  always_ff @(posedge mclk or posedge rst) begin : cpu_port
    if (rst) begin
      memReq   <= 1'b0;
      cpuFault <= 1'b0;
      cpuBusy  <= 1'b0;
      memPaddr <= '0;
      memOp    <= OP_READ;
    end else begin
      memReq   <= grantEv;
      cpuFault <= faultEv;                                         // [RL15]
      cpuBusy  <= state_next != ST_IDLE;
      if (grantEv) begin
        memPaddr <= pa_reg;
        memOp    <= reqOp_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hardware register access check
  always_comb begin : sfr_check
    if (!sfrHw) begin
      sfrOk = 1'b1;
    end else begin
      case (curMode)
        MD_USER: sfrOk = segSfr_reg[sfrWrite];                     // [RL3] [RL8]
        MD_CLOS: sfrOk = fwBits[sfrUnit];                          // [RL10]
        default: sfrOk = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin : sfr_answer
    if (rst) begin
      sfrGrant <= 1'b0;
      sfrDeny  <= 1'b0;
    end else begin
      sfrGrant <= sfrReq && sfrOk;
      sfrDeny  <= sfrReq && !sfrOk;                                // [RL13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_mode_boot_map: assert property (modeBits == MB_BOOT |-> curMode == MD_BOOT) // [RL1]
    else $error("boot mode bits not decoded");
  a_disabled_seg: assert property ( // [RL4]
    state_reg == ST_SCAN && segIf.w1[E_SW:E_R] == '0 |=> state_reg != ST_CHECK)
    else $error("disabled segment matched");
  a_empty_table: assert property ( // [RL5]
    state_reg == ST_IDLE && cpuReq && curMode == MD_USER && nseg_reg == '0
    |-> ##2 cpuFault && !memReq)
    else $error("empty table did not fault");
  a_sys_identity: assert property ( // [RL6]
    state_reg == ST_IDLE && cpuReq && curMode == MD_SYS
    |-> ##2 (cpuFault || (memReq && memPaddr == $past(cpuVaddr, 2))))
    else $error("system access not identity mapped");
  a_user_scans: assert property ( // [RL14]
    state_reg == ST_IDLE && cpuReq && curMode == MD_USER |=> state_reg == ST_SCAN)
    else $error("user access skipped segment scan");
  a_seg_reloc: assert property ( // [RL2]
    state_reg == ST_SCAN && segIf.hit && segIf.permit && idx_reg != nseg_reg
    |=> state_reg == ST_CHECK && pa_reg == $past(reqVa_reg) + $past(segIf.w1[15:0]))
    else $error("relocation offset not applied");
  a_fault_blocks: assert property (cpuFault |-> !memReq) // [RL15]
    else $error("faulted access reached memory");
  a_rom_no_write: assert property ( // [RL8]
    memReq && memOp == OP_WRITE |-> memPaddr > ROM_END)
    else $error("write granted to rom");
  a_sys_no_test: assert property ( // [RL11]
    memReq && reqMode_reg == MD_SYS |-> memPaddr > ROM_TEST_END)
    else $error("system mode reached test rom");
  a_mfr_reserved: assert property ( // [RL12]
    memReq && !CL_PRESENT && memPaddr >= EE_MFR_BASE && memPaddr <= EE_END
    |-> reqMode_reg == MD_TEST)
    else $error("reserved eeprom reached");
  a_refused_read: assert property ( // [RL13]
    setup && !pwrite && !priv && paddr == REG_TBLPTR |=> prdata == '0)
    else $error("refused read returned data");
  a_refused_write: assert property ( // [RL13]
    psel && penable && pwrite && pready && !priv |=> $stable(tblPtr_reg))
    else $error("refused write took effect");
  a_fw_deny: assert property ( // [RL10]
    sfrReq && sfrHw && curMode == MD_CLOS && !fwBits[sfrUnit] |=> sfrDeny && !sfrGrant)
    else $error("firewall did not deny");
  a_seg_sfr: assert property ( // [RL3]
    sfrReq && sfrHw && curMode == MD_USER && !segSfr_reg[sfrWrite] |=> sfrDeny)
    else $error("segment register right ignored");
  a_table_walk: assert property ( // [RL9]
    state_reg == ST_FETCH && tblReq && tblAck |=> tblAddr == $past(tblAddr) + TBL_STEP)
    else $error("table fetch address not stepped");

  c_user_grant: cover property (state_reg == ST_SCAN ##1 state_reg == ST_CHECK ##1 memReq);
  c_load_done: cover property (state_reg == ST_FETCH ##1 state_reg == ST_IDLE);
  c_fw_deny: cover property (sfrDeny && curMode == MD_CLOS);
  c_user_fault: cover property (cpuFault && reqMode_reg == MD_USER);

endmodule // mmac_access_control
`default_nettype wire

// >>> common/mmac_pkg.sv
// Purpose: shared constants and types of the mode based access control unit
// Assumes: 16-bit virtual and physical addresses, APB register window
// Notes: memory map bounds and register layout are fixed here
package mmac_pkg;
  localparam int VA_W    = 16;
  localparam int SEG_MAX = 64;
  localparam int NSEG_FW = 8;

  // cpu modes
  typedef enum logic [2:0] {MD_BOOT, MD_TEST, MD_CLOS, MD_SYS, MD_USER} mmac_mode_e;

  // internal mode bit codes and status word bit
  localparam logic [1:0] MB_BOOT     = 2'h1;
  localparam logic [1:0] MB_TEST     = 2'h2;
  localparam logic [1:0] MB_CLOS     = 2'h3;
  localparam int         PSW_SYS_BIT = 7;

  // memory operations
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_EXEC  = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TBLPTR   = 8'h04;
  localparam logic [7:0] REG_FWCTL_LO = 8'h08;
  localparam logic [7:0] REG_FWCTL_HI = 8'h0C;
  localparam logic [7:0] REG_XBASE_LO = 8'h10;
  localparam logic [7:0] REG_XBASE_HI = 8'h14;
  localparam logic [7:0] REG_XSIZE_LO = 8'h18;
  localparam logic [7:0] REG_XSIZE_HI = 8'h1C;
  localparam logic [7:0] REG_STATUS   = 8'h20;

  // field positions
  localparam int CTRL_LOAD_BIT  = 0;
  localparam int CTRL_NSEG_LSB  = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_MODE_LSB  = 4;

  // reset values
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0]  FW_RST  = 8'h00;
  localparam logic [7:0]  XW_RST  = 8'h00;

  // segment entry layout: word0 first/last, word1 offset and rights
  localparam int E_FIRST_LSB = 0;
  localparam int E_LAST_LSB  = 16;
  localparam int E_OFS_LSB   = 0;
  localparam int E_R         = 16;
  localparam int E_W         = 17;
  localparam int E_X         = 18;
  localparam int E_SR        = 19;
  localparam int E_SW        = 20;
  localparam logic [15:0] TBL_STEP = 16'h0004;

  // physical memory map
  localparam logic [15:0] ROM_TEST_END = 16'h0FFF;
  localparam logic [15:0] ROM_END      = 16'h7FFF;
  localparam logic [15:0] EE_BASE      = 16'h8000;
  localparam logic [15:0] EE_CL_END    = 16'h8FFF;
  localparam logic [15:0] EE_END       = 16'hDFFF;
  localparam logic [15:0] EE_MFR_BYTES = 16'h0080;
  localparam logic [15:0] EE_MFR_BASE  = EE_END - EE_MFR_BYTES + 16'h0001;
  localparam logic [15:0] RAM_BASE     = 16'hE000;
  localparam logic [15:0] RAM_CL_END   = 16'hE3FF;
endpackage

// >>> common/mmac_seg_if.sv
// Purpose: carries one segment entry and its lookup answer
// Assumes: owner drives request and entry words combinationally
// Notes: answer is combinational
`timescale 1ns/10ps
`default_nettype none
interface mmac_seg_if;
  logic [15:0] vaddr;
  logic [1:0]  op;
  logic [31:0] w0;
  logic [31:0] w1;
  logic        hit;
  logic        permit;
  logic [15:0] paddr;
  modport owner (output vaddr, op, w0, w1, input hit, permit, paddr);
  modport match (input vaddr, op, w0, w1, output hit, permit, paddr);
endinterface
`default_nettype wire

// >>> rtl/mmac_seg_check.sv
// Purpose: matches a virtual address against one segment entry
// Assumes: entry words laid out as in the package
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module mmac_seg_check
  import mmac_pkg::*;
(
  mmac_seg_if.match sp
);
  logic [15:0] first;
  logic [15:0] last;
  logic [15:0] ofs;
  logic        anyRight;

  // entry fields
  assign first = sp.w0[E_FIRST_LSB +: VA_W];
  assign last  = sp.w0[E_LAST_LSB +: VA_W];
  assign ofs   = sp.w1[E_OFS_LSB +: VA_W];

  // an entry without any right is disabled
  assign anyRight = |sp.w1[E_SW:E_R];                                   // [RL4]
  assign sp.hit   = anyRight && (sp.vaddr >= first) && (sp.vaddr <= last); // [RL2]

  // per operation right
  assign sp.permit = (sp.op == OP_READ)  ? sp.w1[E_R] :
                     (sp.op == OP_WRITE) ? sp.w1[E_W] : sp.w1[E_X];  // [RL8]

  // relocation to physical
  assign sp.paddr = 16'(sp.vaddr + ofs);                                // [RL2] [RL6]
endmodule // mmac_seg_check
`default_nettype wire

// >>> tb/mmac_tbl_mem.sv
// Purpose: table memory model answering segment word reads
// Assumes: ack three cycles after a request, data valid with ack only
// Notes: holds a two-entry table at 0x0100
`timescale 1ns/10ps
`default_nettype none
module mmac_tbl_mem (
  input  wire logic        mclk,
  input  wire logic        tblReq,
  input  wire logic [15:0] tblAddr,
  output var  logic [31:0] tblRdata,
  output var  logic        tblAck
);
  logic [31:0] mem [0:3];
  logic [1:0]  dly;
  // entry0 0000..00FF read, offset 1000; entry1 same range, no rights
  initial begin
    mem = '{32'h00FF0000, 32'h00011000, 32'h00FF0000, 32'h00001000};
  end
  // slow answer; data shows the inverse word when not acknowledged
  always @(posedge mclk) begin
    if (tblReq && !tblAck && dly == 2'h2) begin
      tblAck   <= 1'b1;
      tblRdata <= mem[tblAddr[3:2]];
      dly      <= 2'h0;
    end else begin
      tblAck   <= 1'b0;
      tblRdata <= ~mem[tblAddr[3:2]];
      dly      <= (tblReq && !tblAck) ? dly + 2'h1 : 2'h0;
    end
  end
endmodule // mmac_tbl_mem
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: testbench of the access control unit
// Assumes: apb and cpu requests driven at rising edge
// Notes: table load, translation, refusals
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mmac_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, cpuReq, cpuBusy, cpuFault;
  logic memReq, tblReq, tblAck, sfrReq, sfrWrite, sfrHw, sfrGrant, sfrDeny;
  logic [3:0] sfrUnit;
  logic [7:0] paddr, psh;
  logic [31:0] pwdata, prdata, tblRdata, rd;
  logic [15:0] cpuVaddr, memPaddr, tblAddr;
  logic [1:0] cpuOp, memOp, modeBits;
  int fail_count, checked, n;
  mmac_access_control mmac_access_control_i (.mclk(mclk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .programStatusHigh(psh), .modeBits(modeBits),
    .cpuReq(cpuReq), .cpuVaddr(cpuVaddr), .cpuOp(cpuOp), .cpuBusy(cpuBusy),
    .cpuFault(cpuFault), .memReq(memReq), .memPaddr(memPaddr), .memOp(memOp),
    .tblReq(tblReq), .tblAddr(tblAddr), .tblRdata(tblRdata), .tblAck(tblAck),
    .sfrReq(sfrReq), .sfrWrite(sfrWrite), .sfrHw(sfrHw), .sfrUnit(sfrUnit),
    .sfrGrant(sfrGrant), .sfrDeny(sfrDeny));
  mmac_tbl_mem mmac_tbl_mem_i (.mclk(mclk), .tblReq(tblReq), .tblAddr(tblAddr),
    .tblRdata(tblRdata), .tblAck(tblAck));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      print_verdict();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  // cpu request; expects grant with address or fault
  task automatic cpu(input logic [15:0] va, input logic [1:0] op, input logic g,
                     input logic [15:0] pa);
    cpuReq <= 1'b1; cpuVaddr <= va; cpuOp <= op;
    @(posedge mclk) cpuReq <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!memReq && !cpuFault && n < 80);
    if (!memReq && !cpuFault) begin
      chk("answer", 1, 0);
      print_verdict();
    end
    chk("grant", g, memReq);
    chk("fault", !g, cpuFault);
    if (g) chk("paddr", pa, memPaddr);
    if (g) chk("op", op, memOp);
  endtask
  // register access request; grant or deny stands in the next cycle
  task automatic sfr(input logic w, input logic [3:0] u, input logic g);
    sfrReq <= 1'b1; sfrWrite <= w; sfrUnit <= u;
    @(posedge mclk) sfrReq <= 1'b0;
    @(posedge mclk);
    chk("sfr grant", g, sfrGrant);
    chk("sfr deny", !g, sfrDeny);
  endtask
  logic e;
  initial begin
    {psel, penable, pwrite, cpuReq, sfrReq, sfrWrite, sfrHw, checked, fail_count} = '0;
    {paddr, pwdata, cpuVaddr, cpuOp, sfrUnit} = '0;
    rst = 1'b1; psh = 8'h80; modeBits = 2'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    psh <= 8'h00;
    cpu(16'h0010, OP_READ, 0, 0);
    psh <= 8'h80;
    apb(1, REG_TBLPTR, 32'h0100, e);
    apb(0, REG_TBLPTR, 0, e); chk("ptr", 32'h0100, rd);
    apb(1, REG_FWCTL_LO, 32'h01, e);
    apb(0, 8'h40, 0, e); chk("unmapped", 1, e);
    cpu(16'h1000, OP_READ, 1, 16'h1000);
    cpu(16'h8100, OP_EXEC, 0, 0);
    cpu(16'h0010, OP_READ, 0, 0);
    apb(1, REG_CTRL, 32'h0201, e);
    repeat (4) @(posedge mclk);
    for (n = 0; n < 200 && cpuBusy; n++) @(posedge mclk);
    if (cpuBusy) begin
      chk("load busy", 0, 1);
      print_verdict();
    end
    psh <= 8'h00;
    @(posedge mclk);
    cpu(16'h0010, OP_READ, 1, 16'h1010);
    cpu(16'h0010, OP_WRITE, 0, 0);
    cpu(16'h0200, OP_READ, 0, 0);
    apb(1, REG_TBLPTR, 32'h0300, e);
    apb(0, REG_TBLPTR, 0, e); chk("user read", 0, rd);
    sfrHw <= 1'b1;
    sfr(0, 4'h0, 0);
    modeBits <= 2'h3;
    sfr(0, 4'h0, 1);
    sfr(0, 4'h1, 0);
    apb(0, REG_STATUS, 0, e); chk("status", 32'h00000022, rd);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
